// File: hw/tds_regs.svh
// Descriptor offsets, bit positions and counts for the transmit descriptor engine.
`ifndef TDS_REGS_SVH
`define TDS_REGS_SVH
`define TDS_OFF_W0 24'h000000
`define TDS_OFF_W1 24'h000002
`define TDS_OFF_W2 24'h000004
`define TDS_OFF_W3 24'h000006
`define TDS_DESC_SIZE 24'h000008
`define TDS_WORD_STEP 24'h000002
`define TDS_B_OWN 15
`define TDS_B_ERR 14
`define TDS_B_RSV 13
`define TDS_B_MULTI 12
`define TDS_B_SINGLE 11
`define TDS_B_DEF 10
`define TDS_B_FIRST 9
`define TDS_B_LAST 8
`define TDS_B3_UFLOW 14
`define TDS_B3_LATE 12
`define TDS_B3_CARRIER 11
`define TDS_B3_RTE 10
`define TDS_RETRY_LIMIT 5'h10
`define TDS_RETRY_ONE 5'h01
`define TDS_FIFO_DEPTH 2'h2
`endif

// File: hw/tds_pkg.sv
// Types shared by the transmit descriptor engine.
package tds_pkg;
  typedef struct packed {
    logic [15:0] data;
    logic first;
    logic last;
  } tds_word_s;
  typedef struct packed {
    logic [4:0] fail_count;
    logic deferred;
    logic late_collision;
    logic carrier_loss;
    logic underflow;
    logic [9:0] tdr;
  } tds_result_s;
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } tds_mem_req_s;
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_W1, ST_RD_W0, ST_RD_W2, ST_XFER, ST_WAIT_RES, ST_WR_W3, ST_WR_W1
  } tds_state_e;
endpackage

// File: hw/tds_tx_descriptor_engine.sv
// Transmit descriptor engine: ownership handshake, buffer streaming and status write-back.
//
// Operation
// - Word 1 bit 15: 0 host, 1 controller.
// - Ownership bit changes last; then hands off.
// - Controller clears ownership when buffer finished.
// - Error summary is OR of four errors.
// - Reserved bit 13 always written zero.
// - Bit 12 set for more than one retry.
// - Bit 11 set for exactly one retry.
// - Bit 10 set when transmission was deferred.
// - First-buffer bit 9 never modified by controller.
// - Last-buffer bit 8 kept; both means single.
// - Bits 7:0 hold address 23:16, kept.
// - Word 2 length, two's complement, never written.
// - Word 3 at offset 6, valid on error.
// - Descriptor n at ring base plus 8n.
// - Retries exhausted after 16, or one attempt.
`timescale 1ns/1ns
`include "tds_regs.svh"
module tds_tx_descriptor_engine (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tx_enable,
  input wire logic [23:0] i_ring_base,
  input wire logic [2:0] i_ring_len_log2,
  input wire logic i_disable_retry_mode,
  output logic o_mem_req,
  output tds_pkg::tds_mem_req_s o_mem,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  output logic o_tx_valid,
  output tds_pkg::tds_word_s o_tx_word,
  input wire logic i_tx_ready,
  input wire logic i_res_valid,
  input wire tds_pkg::tds_result_s i_res
);
  import tds_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] desc_addr(input logic [23:0] base, input logic [6:0] idx,
                                            input logic [23:0] off);
    desc_addr = base + {17'h0, idx} * `TDS_DESC_SIZE + off;
  endfunction

  // Buffer length is stored negated; the word count rounds an odd byte up.
  function automatic logic [11:0] words_of(input logic [11:0] neg_len);
    logic [12:0] n;
    n = {1'b0, 12'h000 - neg_len} + 13'h0001;
    words_of = n[12:1];
  endfunction

  function automatic logic [15:0] w1_word(input logic [15:0] w1, input logic err, input logic multi,
                                          input logic single, input logic def);
    w1_word = w1;
    w1_word[`TDS_B_OWN] = 1'b0;
    w1_word[`TDS_B_ERR] = err;
    w1_word[`TDS_B_RSV] = 1'b0;
    w1_word[`TDS_B_MULTI] = multi;
    w1_word[`TDS_B_SINGLE] = single;
    w1_word[`TDS_B_DEF] = def;
  endfunction

  // ----------------------------------------------------------------
  // Result decode
  // ----------------------------------------------------------------
  logic rte_c;
  logic err_c;
  logic single_c;
  logic multi_c;
  logic [15:0] w3_c;
  always_comb begin
    rte_c = i_disable_retry_mode ? (i_res.fail_count >= `TDS_RETRY_ONE)
                                 : (i_res.fail_count >= `TDS_RETRY_LIMIT);
    err_c = i_res.late_collision | i_res.carrier_loss | i_res.underflow | rte_c;
    single_c = !rte_c && i_res.fail_count == `TDS_RETRY_ONE;
    multi_c = !rte_c && i_res.fail_count > `TDS_RETRY_ONE;
    w3_c = {6'h00, i_res.tdr};
    w3_c[`TDS_B3_UFLOW] = i_res.underflow;
    w3_c[`TDS_B3_LATE] = i_res.late_collision;
    w3_c[`TDS_B3_CARRIER] = i_res.carrier_loss;
    w3_c[`TDS_B3_RTE] = rte_c;
  end

  // ----------------------------------------------------------------
  // Descriptor sequencer
  // ----------------------------------------------------------------
  tds_state_e state_reg;
  logic [6:0] idx_reg;
  logic [15:0] w1_reg;
  logic [23:0] buf_ptr_reg;
  logic [11:0] words_left_reg;
  tds_mem_req_s mem_reg;
  logic [1:0] count_reg;
  logic fifo_space;
  logic [6:0] ring_mask;
  logic err_reg;
  logic multi_reg;
  logic single_reg;
  logic def_reg;

  assign fifo_space = count_reg < `TDS_FIFO_DEPTH;
  assign ring_mask = 7'((8'h01 << i_ring_len_log2) - 8'h01);
  // A read for the stream waits for room, so a stalled receiver never loses a word.
  assign o_mem_req = (state_reg == ST_RD_W1) || (state_reg == ST_RD_W0) || (state_reg == ST_RD_W2) ||
                     (state_reg == ST_XFER && fifo_space) || (state_reg == ST_WR_W3) ||
                     (state_reg == ST_WR_W1);
  assign o_mem = mem_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ST_IDLE;
      idx_reg <= 7'h00;
      w1_reg <= 16'h0000;
      buf_ptr_reg <= 24'h000000;
      words_left_reg <= 12'h000;
      mem_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (i_tx_enable) begin
            state_reg <= ST_RD_W1;
            mem_reg <= '{we: 1'b0, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W1), wdata: 16'h0000};
          end
        end
        ST_RD_W1: begin
          if (i_mem_ack) begin
            w1_reg <= i_mem_rdata;
            // A host-owned descriptor is left untouched and polled again later.
            if (i_mem_rdata[`TDS_B_OWN]) begin
              state_reg <= ST_RD_W0;
              mem_reg.addr <= desc_addr(i_ring_base, idx_reg, `TDS_OFF_W0);
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RD_W0: begin
          if (i_mem_ack) begin
            buf_ptr_reg <= {w1_reg[7:0], i_mem_rdata};
            state_reg <= ST_RD_W2;
            mem_reg.addr <= desc_addr(i_ring_base, idx_reg, `TDS_OFF_W2);
          end
        end
        ST_RD_W2: begin
          if (i_mem_ack) begin
            words_left_reg <= words_of(i_mem_rdata[11:0]);
            if (words_of(i_mem_rdata[11:0]) != 12'h000) begin
              state_reg <= ST_XFER;
              mem_reg.addr <= buf_ptr_reg;
            end else if (w1_reg[`TDS_B_LAST]) begin
              state_reg <= ST_WAIT_RES;
            end else begin
              state_reg <= ST_WR_W1;
              mem_reg <= '{we: 1'b1, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W1),
                           wdata: w1_word(w1_reg, 1'b0, 1'b0, 1'b0, 1'b0)};
            end
          end
        end
        ST_XFER: begin
          if (i_mem_ack) begin
            words_left_reg <= words_left_reg - 12'h001;
            mem_reg.addr <= mem_reg.addr + `TDS_WORD_STEP;
            if (words_left_reg == 12'h001) begin
              if (w1_reg[`TDS_B_LAST]) begin
                state_reg <= ST_WAIT_RES;
              end else begin
                // A chained buffer goes back as soon as its last word is read.
                state_reg <= ST_WR_W1;
                mem_reg <= '{we: 1'b1, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W1),
                             wdata: w1_word(w1_reg, 1'b0, 1'b0, 1'b0, 1'b0)};
              end
            end
          end
        end
        ST_WAIT_RES: begin
          if (i_res_valid) begin
            if (err_c) begin
              state_reg <= ST_WR_W3;
              mem_reg <= '{we: 1'b1, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W3), wdata: w3_c};
            end else begin
              state_reg <= ST_WR_W1;
              mem_reg <= '{we: 1'b1, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W1),
                           wdata: w1_word(w1_reg, err_c, multi_c, single_c, i_res.deferred)};
            end
          end
        end
        ST_WR_W3: begin
          if (i_mem_ack) begin
            // Ownership goes back only after the error word is safely written.
            state_reg <= ST_WR_W1;
            mem_reg <= '{we: 1'b1, addr: desc_addr(i_ring_base, idx_reg, `TDS_OFF_W1),
                         wdata: w1_word(w1_reg, err_reg, multi_reg, single_reg, def_reg)};
          end
        end
        ST_WR_W1: begin
          if (i_mem_ack) begin
            state_reg <= ST_IDLE;
            mem_reg.we <= 1'b0;
            idx_reg <= (idx_reg + 7'h01) & ring_mask;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit status
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst || (state_reg == ST_RD_W1 && i_mem_ack)) begin
      err_reg <= 1'b0;
      multi_reg <= 1'b0;
      single_reg <= 1'b0;
      def_reg <= 1'b0;
    end else if (state_reg == ST_WAIT_RES && i_res_valid) begin
      err_reg <= err_c;
      multi_reg <= multi_c;
      single_reg <= single_c;
      def_reg <= i_res.deferred;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry stream buffer
  // ----------------------------------------------------------------
  tds_word_s fifo_mem [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic push;
  logic pop;
  assign push = state_reg == ST_XFER && o_mem_req && i_mem_ack;
  assign pop = o_tx_valid && i_tx_ready;
  assign o_tx_valid = count_reg != 2'h0;
  assign o_tx_word = fifo_mem[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= '{data: i_mem_rdata,
                                  first: w1_reg[`TDS_B_FIRST] && mem_reg.addr == buf_ptr_reg,
                                  last: w1_reg[`TDS_B_LAST] && words_left_reg == 12'h001};
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic w1_wr;
  logic res_take;
  assign w1_wr = o_mem_req && o_mem.we && state_reg == ST_WR_W1;
  assign res_take = state_reg == ST_WAIT_RES && i_res_valid;

  AST_HOST_OWNED_SKIPPED: assert property (state_reg == ST_RD_W1 && i_mem_ack && !i_mem_rdata[`TDS_B_OWN]
    |=> state_reg == ST_IDLE) else $error("Host-owned descriptor was used.");
  // Polling the next descriptor right after the hand-back is legal; only a write would touch the old one.
  AST_OWN_LAST: assert property (w1_wr && i_mem_ack |=> state_reg == ST_IDLE ##1 !(o_mem_req && o_mem.we))
    else $error("Descriptor touched after handing it back.");
  AST_OWN_CLEARED: assert property (w1_wr |-> !o_mem.wdata[`TDS_B_OWN])
    else $error("Ownership bit not cleared on write-back.");
  AST_ERR_SUMMARY: assert property (w1_wr && w1_reg[`TDS_B_LAST] |-> o_mem.wdata[`TDS_B_ERR] == err_reg)
    else $error("Error summary does not match error flags.");
  AST_RSV_ZERO: assert property (w1_wr |-> !o_mem.wdata[`TDS_B_RSV])
    else $error("Reserved bit written as one.");
  AST_MULTI: assert property (res_take && !rte_c && i_res.fail_count == 5'h02 |=> multi_reg)
    else $error("Multiple-retry flag missing.");
  AST_SINGLE: assert property (res_take && !i_disable_retry_mode && i_res.fail_count == 5'h01
    |=> single_reg && !multi_reg) else $error("Single-retry flag wrong.");
  AST_DEFER: assert property (res_take && i_res.deferred ##1 w1_wr |-> o_mem.wdata[`TDS_B_DEF])
    else $error("Deferred flag not written.");
  AST_KEEP_FIRST: assert property (w1_wr |-> o_mem.wdata[`TDS_B_FIRST] == w1_reg[`TDS_B_FIRST])
    else $error("First-buffer bit changed.");
  AST_KEEP_LAST: assert property (w1_wr |-> o_mem.wdata[`TDS_B_LAST] == w1_reg[`TDS_B_LAST])
    else $error("Last-buffer bit changed.");
  AST_KEEP_ADDR: assert property (w1_wr |-> o_mem.wdata[7:0] == w1_reg[7:0])
    else $error("Buffer address bits changed.");
  AST_NO_W2_WRITE: assert property (o_mem_req && o_mem.we |-> state_reg inside {ST_WR_W1, ST_WR_W3})
    else $error("Write outside status words.");
  AST_W3_ON_ERR: assert property (state_reg == ST_WR_W3 |-> $past(err_c) || err_reg)
    else $error("Error word written without an error.");
  AST_DESC_ADDR: assert property (state_reg == ST_RD_W1
    |-> o_mem.addr == i_ring_base + {14'h0, idx_reg, 3'h0} + 24'h000002) else $error("Descriptor address wrong.");
  AST_RTE: assert property (res_take && i_res.fail_count == 5'h10 |-> rte_c && err_c)
    else $error("Retries exhausted not flagged.");
  AST_OWNED_XFER: assert property (state_reg == ST_XFER |-> w1_reg[`TDS_B_OWN])
    else $error("Buffer read while host-owned.");

  COV_SINGLE_PACKET: cover property (w1_wr && i_mem_ack && w1_reg[9] && w1_reg[8]);
  COV_ERROR_WRITE: cover property (state_reg == ST_WR_W3 && i_mem_ack);
  COV_STALL: cover property ((state_reg == ST_XFER && !fifo_space) [*3]);
endmodule

// File: test/tds_host_mem.sv
// Shared buffer RAM model with the host's descriptor preparation.
`timescale 1ns/1ns
module tds_host_mem (
  input wire logic i_clk,
  input wire logic i_mem_req,
  input wire tds_pkg::tds_mem_req_s i_mem,
  input wire logic i_slow,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  import tds_pkg::*;
  // ------
  // Memory port
  // ------
  // Only address bits 12:1 decode, so the high buffer address byte aliases into this small RAM.
  logic [15:0] mem [0:4095];
  logic [1:0] wait_cnt = 2'h0;
  initial o_mem_ack = 1'b0;
  initial o_mem_rdata = 16'h0000;
  // Unwritten descriptors read as host-owned zeros rather than unknowns.
  initial for (int i = 0; i < 4096; i++) mem[i] = 16'h0000;
  // Read data is inverted every cycle without an ack, so a late sample never sees a stale word.
  always @(posedge i_clk) begin
    wait_cnt <= (i_mem_req && !o_mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    o_mem_rdata <= ~o_mem_rdata;
    o_mem_ack <= 1'b0;
    if (i_mem_req && !o_mem_ack && (!i_slow || wait_cnt == 2'h3)) begin
      o_mem_ack <= 1'b1;
      if (i_mem.we) mem[i_mem.addr[12:1]] <= i_mem.wdata;
      else o_mem_rdata <= mem[i_mem.addr[12:1]];
    end
  end
  // The owner bit goes in last, after the buffer and the other words are complete.
  task automatic prep(input logic [23:0] d, input logic [15:0] w1, input logic [15:0] lo, input logic [11:0] len,
                      input logic [15:0] seed);
    logic [11:0] a;
    a = lo[12:1];
    for (int i = 0; i < (len + 1) / 2; i++) mem[a + 12'(i)] = seed + 16'(i);
    a = d[12:1];
    mem[a] = lo;
    mem[a + 12'h2] = {4'hF, 12'h000 - len};
    mem[a + 12'h3] = 16'h5555;
    mem[a + 12'h1] = w1;
  endtask
endmodule

// File: test/tds_tx_descriptor_engine_tb.sv
// Self-checking bench for the transmit descriptor engine.
`timescale 1ns/1ns
module tds_tx_descriptor_engine_tb;
  import tds_pkg::*;
  localparam logic [23:0] BASE = 24'h000100;
  logic i_clk = 1'b0, i_srst = 1'b1, i_tx_enable = 1'b0, i_disable_retry_mode = 1'b0;
  logic i_tx_ready = 1'b0, i_res_valid = 1'b0, i_slow = 1'b0;
  tds_result_s i_res = '0;
  logic o_mem_req, i_mem_ack, o_tx_valid;
  logic [15:0] i_mem_rdata;
  tds_mem_req_s o_mem;
  tds_word_s o_tx_word;
  logic [23:0] rd_q[$];
  int miscompares = 0, cmp_count = 0, cur = 0;
  always #10 i_clk = ~i_clk;
  tds_tx_descriptor_engine dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_tx_enable(i_tx_enable), .i_ring_base(BASE),
    .i_ring_len_log2(3'h1), .i_disable_retry_mode(i_disable_retry_mode), .o_mem_req(o_mem_req), .o_mem(o_mem),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_tx_valid(o_tx_valid), .o_tx_word(o_tx_word),
    .i_tx_ready(i_tx_ready), .i_res_valid(i_res_valid), .i_res(i_res));
  tds_host_mem mem_u (.i_clk(i_clk), .i_mem_req(o_mem_req), .i_mem(o_mem), .i_slow(i_slow),
    .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
  always @(posedge i_clk) if (o_mem_req === 1'b1 && i_mem_ack === 1'b1 && o_mem.we === 1'b0) rd_q.push_back(o_mem.addr);
  // ------
  // Helpers
  // ------
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d miscompares", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input logic ran_out);
    if (ran_out) begin
      chk(1'b0, "wait ran out");
      give_verdict();
    end
  endtask
  function automatic logic [23:0] daddr(input int n);
    return BASE + 24'(n * 8);
  endfunction
  function automatic logic [23:0] baddr(input int n);
    return {8'h5A, 16'(16'h0400 + n * 512)};
  endfunction
  // Status word in the upper half, error word in the lower half.
  function automatic logic [31:0] expect_words(input tds_result_s r, input logic disable_retry_mode, input logic [9:0] keep);
    logic retries_exhausted_flag, err;
    retries_exhausted_flag = (r.fail_count >= 5'h10) || (disable_retry_mode && r.fail_count != 5'h00);
    err = retries_exhausted_flag || r.late_collision || r.carrier_loss || r.underflow;
    return {1'b0, err, 1'b0, r.fail_count > 5'h01 && !retries_exhausted_flag, r.fail_count == 5'h01 && !retries_exhausted_flag, r.deferred, keep,
            err ? {1'b0, r.underflow, 1'b0, r.late_collision, r.carrier_loss, retries_exhausted_flag, r.tdr} : 16'h5555};
  endfunction
  task automatic prep_n(input int n, input logic fst, input logic lst, input logic [11:0] len, input logic own);
    mem_u.prep(daddr(n), {own, 5'h00, fst, lst, 8'h5A}, 16'(16'h0400 + n * 512), len, 16'hA000 + 16'(n * 256));
  endtask
  // Ready is low four cycles in five when stalling, so the two-entry buffer fills and must hold.
  task automatic take(input int nw, input logic fst, input logic lst, input logic [15:0] seed, input bit stall);
    int got, k;
    got = 0;
    for (k = 0; k < 4000 && got < nw; k++) begin
      @(posedge i_clk);
      if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
        chk(o_tx_word === {seed + 16'(got), fst && got == 0, lst && got == nw - 1}, "stream word");
        got++;
      end
      if (got < nw) i_tx_ready <= !stall || (k % 5 == 4);
    end
    i_tx_ready <= 1'b0;
    tmo(got < nw);
  endtask
  task automatic run_n(input logic fst, input logic lst, input logic [11:0] len, input tds_result_s r, input bit stall);
    logic [23:0] d;
    logic [31:0] ew;
    int nw, i, k;
    d = daddr(cur);
    nw = (len + 1) / 2;
    i = 0;
    take(nw, fst, lst, 16'hA000 + 16'(cur * 256), stall);
    while (i < rd_q.size() && rd_q[i] !== baddr(cur)) i++;
    chk(i >= 2 && rd_q[i - 2] === d && rd_q[i - 1] === d + 24'h4, "word order");
    chk(rd_q.size() >= i + nw && rd_q[i + nw - 1] === baddr(cur) + 24'(2 * nw - 2), "buffer span");
    i_res <= r;
    i_res_valid <= lst;
    for (k = 0; k < 300 && mem_u.mem[d[12:1] + 12'h1][15] !== 1'b0; k++) @(posedge i_clk);
    i_res_valid <= 1'b0;
    tmo(k >= 300);
    ew = expect_words(lst ? r : '0, i_disable_retry_mode, {fst, lst, 8'h5A});
    chk(mem_u.mem[d[12:1] + 12'h1] === ew[31:16], "status word");
    chk(mem_u.mem[d[12:1] + 12'h3] === ew[15:0], "error word");
    chk(mem_u.mem[d[12:1] + 12'h2] === {4'hF, 12'h000 - len}, "size word");
    cur = 1 - cur;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic host_owned();
    int bad;
    bad = 0;
    rd_q.delete();
    prep_n(cur, 1'b1, 1'b1, 12'h040, 1'b0);
    repeat (30) @(posedge i_clk);
    foreach (rd_q[j]) if (rd_q[j] !== daddr(cur) + 24'h2) bad++;
    chk(bad == 0 && rd_q.size() > 0 && o_tx_valid === 1'b0, "host-owned touched");
    chk(mem_u.mem[daddr(cur) / 2 + 1] === 16'h035A, "host-owned written");
    mem_u.mem[daddr(cur) / 2 + 1][15] = 1'b1;
    run_n(1'b1, 1'b1, 12'h040, {5'h01, 4'h0, 10'h000}, 1'b1);
  endtask
  task automatic status_table();
    tds_result_s tbl [8] = '{{5'h02, 4'h0, 10'h000}, {5'h10, 4'h0, 10'h155}, {5'h0F, 4'h8, 10'h000},
      {5'h00, 4'h4, 10'h2AA}, {5'h00, 4'h2, 10'h001}, {5'h00, 4'h1, 10'h3FF}, {5'h01, 4'h0, 10'h0C3},
      {5'h00, 4'h0, 10'h000}};
    for (int i = 0; i < 8; i++) begin
      rd_q.delete();
      i_disable_retry_mode <= (i >= 6);
      i_slow <= i[0];
      @(posedge i_clk);
      prep_n(cur, 1'b1, 1'b1, 12'h040 + 12'(i % 2), 1'b1);
      run_n(1'b1, 1'b1, 12'h040 + 12'(i % 2), tbl[i], i[1]);
    end
  endtask
  task automatic chained();
    rd_q.delete();
    prep_n(cur, 1'b1, 1'b0, 12'h040, 1'b1);
    prep_n(1 - cur, 1'b0, 1'b1, 12'h041, 1'b1);
    run_n(1'b1, 1'b0, 12'h040, {5'h03, 4'h0, 10'h000}, 1'b0);
    run_n(1'b0, 1'b1, 12'h041, {5'h00, 4'h4, 10'h011}, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    i_tx_enable <= 1'b1;
    host_owned();
    status_table();
    chained();
    give_verdict();
  end
endmodule
